// >>> bcps_top.sv
// Top: bus-control pin select for port E bits 7 and 6
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - The read drive strobe goes low only in the high phase of the bus clock.
// - In a stretched access the strobe is low only in the last quarter of the last cycle.
// - In expanded modes the strobe gates external drivers during external reads.
// - The strobe disable bit governs the strobe on bit 7 but not on bus_side_oe_n; the strobe is enabled out of reset in expanded modes.
// - The inverted clock output follows the free-running bus clock, inverted.
// - Two control bits choose between strobe and inverted clock on bit 7.
// - The reference output carries the slow divided clock.
// - The slow divider runs at half the crystal rate after reset with 50% duty at any setting.
// - An active strobe overrides an enabled reference output.
// - Clearing the reference enable removes the slow clock from bit 7.
// - Bit 6 carries test clocks only with test enable set and queue tracking clear.
// - The low-byte strobe is the XNOR of address bit 0 and the byte size flag.
// - In expanded modes with its enable bit set the read/write output shows transfer direction.
// - Mode select pins sampled during reset choose the initial mode.
// - The bus clock runs at a quarter of the crystal rate and times the read drive strobe.
// - The low-byte strobe stays inactive until its enable bit is set.
module bcps_top (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       mode_select_a,
   input  wire logic       mode_select_b,
   input  wire logic       access_active,
   input  wire logic       access_read,
   input  wire logic       addr_bit0,
   input  wire logic       byte_size_flag,
   input  wire logic       test_clock_in,
   input  wire logic       gpio7_out,
   input  wire logic       gpio7_oe_n,
   input  wire logic       gpio6_out,
   input  wire logic       gpio6_oe_n,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   output logic            port_e_bit7,
   output logic            port_e_bit7_oe_n,
   output logic            port_e_bit6,
   output logic            port_e_bit6_oe_n,
   output logic            bus_clock_out,
   output logic            low_byte_strobe_n,
   output logic            read_write,
   output logic            bus_side_oe_n
);
   import bcps_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] mode_select_a_s_r;
   logic [1:0] mode_select_b_s_r;
   logic [1:0] tclk_s_r;

   // Mode pins keep sampling while reset holds the rest
   always_ff @(posedge clk) begin
      mode_select_a_s_r <= {mode_select_a_s_r[0], mode_select_a};
      mode_select_b_s_r <= {mode_select_b_s_r[0], mode_select_b};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tclk_s_r <= 2'b00;
      end else begin
         tclk_s_r <= {tclk_s_r[0], test_clock_in};
      end
   end

   // ---------------------------------------------------------------
   // Mode capture at reset release
   // ---------------------------------------------------------------
   logic       strap_done_r;
   logic       strap_done_nxt;
   bcps_mode_t mode_r;
   bcps_mode_t mode_nxt;
   logic       expanded;

   always_comb begin
      strap_done_nxt = 1'b1;
      mode_nxt       = mode_r;
      if (!strap_done_r) begin
         mode_nxt = bcps_mode_t'({mode_select_b_s_r[1], mode_select_a_s_r[1]});
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_r <= 1'b0;
         mode_r       <= BCPS_MODE_SINGLE;
      end else begin
         strap_done_r <= strap_done_nxt;
         mode_r       <= mode_nxt;
      end
   end

   assign expanded = (mode_r == BCPS_MODE_EXPANDED_NARROW) ||
                     (mode_r == BCPS_MODE_EXPANDED_WIDE);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] assign_r;
   logic [7:0] assign_nxt;
   logic [7:0] slow_div_r;
   logic [7:0] slow_div_nxt;
   logic [7:0] stretch_r;
   logic [7:0] stretch_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [1:0] pin7_sel_r;
   logic       bus_clk_r;

   always_comb begin
      assign_nxt   = assign_r;
      slow_div_nxt = slow_div_r;
      stretch_nxt  = stretch_r;
      rdata_nxt    = 8'h00;
      if (strap_done_r != strap_done_nxt) begin
         // Strobe enabled out of reset only in expanded modes
         assign_nxt = (mode_nxt == BCPS_MODE_EXPANDED_NARROW ||
                       mode_nxt == BCPS_MODE_EXPANDED_WIDE) ?
                      ASSIGN_RST_EXPAND : ASSIGN_RST_SINGLE;
      end else if (reg_wr) begin
         case (reg_addr)
            REG_ASSIGN:   assign_nxt   = reg_wdata;
            REG_SLOW_DIV: slow_div_nxt = reg_wdata;
            REG_STRETCH:  stretch_nxt  = reg_wdata;
            default:      ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            REG_ASSIGN:   rdata_nxt = assign_r;
            REG_SLOW_DIV: rdata_nxt = slow_div_r;
            REG_STRETCH:  rdata_nxt = stretch_r;
            REG_STATUS:   rdata_nxt = {4'h0, expanded, pin7_sel_r, bus_clk_r};
            default:      rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         assign_r   <= ASSIGN_RST_SINGLE;
         slow_div_r <= SLOW_DIV_RST;
         stretch_r  <= STRETCH_RST;
         rdata_r    <= 8'h00;
      end else begin
         assign_r   <= assign_nxt;
         slow_div_r <= slow_div_nxt;
         stretch_r  <= stretch_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Bus clock: crystal = clk, bus clock = quarter rate, free-running
   // ---------------------------------------------------------------
   // Each bus cycle is four clk ticks (two low, then two high); a stretch adds
   // whole bus cycles. Quarters are measured in a 4-tick sub-count.
   logic       bus_clk_nxt;
   logic [1:0] quarter_r;
   logic [1:0] quarter_nxt;
   logic [7:0] stretch_left_r;
   logic [7:0] stretch_left_nxt;
   logic       in_stretch_r;
   logic       in_stretch_nxt;
   logic       last_cycle;

   always_comb begin
      quarter_nxt      = quarter_r + 2'd1;
      bus_clk_nxt      = quarter_nxt[1];
      stretch_left_nxt = stretch_left_r;
      in_stretch_nxt   = in_stretch_r;
      if (quarter_r == 2'd3) begin
         if (in_stretch_r) begin
            if (stretch_left_r != 8'h00) begin
               stretch_left_nxt = stretch_left_r - 8'h01;
            end else begin
               in_stretch_nxt = 1'b0;
            end
         end else if (access_active && stretch_r != 8'h00) begin
            // First cycle over: count the added cycles that follow the next one
            in_stretch_nxt   = 1'b1;
            stretch_left_nxt = stretch_r - 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_clk_r      <= 1'b0;
         quarter_r      <= 2'd0;
         stretch_left_r <= 8'h00;
         in_stretch_r   <= 1'b0;
      end else begin
         bus_clk_r      <= bus_clk_nxt;
         quarter_r      <= quarter_nxt;
         stretch_left_r <= stretch_left_nxt;
         in_stretch_r   <= in_stretch_nxt;
      end
   end

   // First cycle of an access is the last only without stretch
   assign last_cycle = in_stretch_r ? (stretch_left_r == 8'h00)
                                    : (stretch_r == 8'h00);

   // ---------------------------------------------------------------
   // Bit 7 select and drive
   // ---------------------------------------------------------------
   bcps_clk_if dif ();
   bcps_slow_div u_slow (
      .clk   (clk),
      .rst_n (rst_n),
      .dif   (dif)
   );
   assign dif.slow_tick = 1'b1;
   assign dif.slow_div  = slow_div_r;

   bcps_pin7_t pin7_sel;
   logic       strobe_n;
   logic       p7_nxt;
   logic       p7_oe_n_nxt;
   logic       p6_nxt;
   logic       p6_oe_n_nxt;
   logic       strobe_win;

   always_comb begin
      if (!assign_r[ASSIGN_STROBE_DIS]) begin
         pin7_sel = assign_r[ASSIGN_INV_CLK] ? BCPS_PIN7_INV_CLK
                                             : BCPS_PIN7_STROBE;
      end else if (assign_r[ASSIGN_REF_OUT]) begin
         pin7_sel = BCPS_PIN7_REFERENCE;
      end else begin
         pin7_sel = BCPS_PIN7_GPIO;
      end
   end

   // Strobe window: high phase normally, last quarter when stretched
   assign strobe_win = access_active && access_read && expanded &&
                       (stretch_r == 8'h00 ? bus_clk_nxt
                        : (last_cycle && quarter_nxt == 2'd3));
   assign strobe_n   = ~strobe_win;

   always_comb begin
      p7_nxt      = gpio7_out;
      p7_oe_n_nxt = gpio7_oe_n;
      case (pin7_sel)
         BCPS_PIN7_STROBE: begin
            p7_nxt      = strobe_n;
            p7_oe_n_nxt = 1'b0;
         end
         BCPS_PIN7_INV_CLK: begin
            p7_nxt      = ~bus_clk_nxt;
            p7_oe_n_nxt = 1'b0;
         end
         BCPS_PIN7_REFERENCE: begin
            p7_nxt      = dif.slow_clk;
            p7_oe_n_nxt = 1'b0;
         end
         default: ;
      endcase
      if (assign_r[ASSIGN_CLK_TEST] && !assign_r[ASSIGN_QUEUE_TRK]) begin
         p6_nxt      = tclk_s_r[1];
         p6_oe_n_nxt = 1'b0;
      end else begin
         p6_nxt      = gpio6_out;
         p6_oe_n_nxt = gpio6_oe_n;
      end
   end

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   logic low_byte_strobe_n_nxt;
   logic rw_nxt;
   logic bus_oe_nxt;

   always_comb begin
      low_byte_strobe_n_nxt  = 1'b1;
      rw_nxt     = 1'b1;
      bus_oe_nxt = strobe_n;
      if (assign_r[ASSIGN_LOW_STRB]) begin
         low_byte_strobe_n_nxt = ~(addr_bit0 ^ byte_size_flag);
      end
      if (expanded && assign_r[ASSIGN_RDWR] && access_active) begin
         rw_nxt = access_read;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_e_bit7       <= 1'b1;
         port_e_bit7_oe_n  <= 1'b1;
         port_e_bit6       <= 1'b1;
         port_e_bit6_oe_n  <= 1'b1;
         bus_clock_out     <= 1'b0;
         low_byte_strobe_n <= 1'b1;
         read_write        <= 1'b1;
         bus_side_oe_n     <= 1'b1;
         pin7_sel_r        <= 2'b00;
      end else begin
         port_e_bit7       <= p7_nxt;
         port_e_bit7_oe_n  <= p7_oe_n_nxt;
         port_e_bit6       <= p6_nxt;
         port_e_bit6_oe_n  <= p6_oe_n_nxt;
         bus_clock_out     <= bus_clk_nxt;
         low_byte_strobe_n <= low_byte_strobe_n_nxt;
         read_write        <= rw_nxt;
         bus_side_oe_n     <= bus_oe_nxt;
         pin7_sel_r        <= pin7_sel;
      end
   end

   assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// >>> bcps_pkg.sv
// Package: constants and types of the bus-control pin select block
package bcps_pkg;

   // ---------------------------------------------------------------
   // Divider and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned CRYSTAL_DIV     = 1;
   localparam int unsigned BUS_CLK_DIV     = 2;
   localparam int unsigned QUARTER_COUNT   = 4;
   localparam logic [7:0]  SLOW_DIV_RST    = 8'h00;
   localparam int unsigned SLOW_DIV_W      = 8;

   // ---------------------------------------------------------------
   // Bit positions of the port E assignment register
   // ---------------------------------------------------------------
   localparam int unsigned ASSIGN_STROBE_DIS = 7;
   localparam int unsigned ASSIGN_CLK_TEST   = 6;
   localparam int unsigned ASSIGN_QUEUE_TRK  = 5;
   localparam int unsigned ASSIGN_INV_CLK    = 4;
   localparam int unsigned ASSIGN_LOW_STRB   = 3;
   localparam int unsigned ASSIGN_RDWR       = 2;
   localparam int unsigned ASSIGN_REF_OUT    = 1;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_ASSIGN    = 4'h0;
   localparam logic [3:0] REG_SLOW_DIV  = 4'h1;
   localparam logic [3:0] REG_STATUS    = 4'h2;
   localparam logic [3:0] REG_STRETCH   = 4'h3;

   localparam logic [7:0] ASSIGN_RST_SINGLE = 8'h80;
   localparam logic [7:0] ASSIGN_RST_EXPAND = 8'h00;
   localparam logic [7:0] STRETCH_RST       = 8'h00;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      BCPS_MODE_SINGLE,
      BCPS_MODE_SPECIAL_SINGLE,
      BCPS_MODE_EXPANDED_NARROW,
      BCPS_MODE_EXPANDED_WIDE
   } bcps_mode_t;

   typedef enum logic [1:0] {
      BCPS_PIN7_GPIO,
      BCPS_PIN7_STROBE,
      BCPS_PIN7_INV_CLK,
      BCPS_PIN7_REFERENCE
   } bcps_pin7_t;

endpackage

// >>> bcps_clk_if.sv
// Interface: slow divider tick, setting and clock shared with the top
`timescale 1ns/1ps
`default_nettype none
interface bcps_clk_if;
   logic                slow_tick;
   logic [7:0]          slow_div;
   logic                slow_clk;
   modport gen (input slow_tick, input slow_div, output slow_clk);
   modport use_side (output slow_tick, output slow_div, input slow_clk);
endinterface
`default_nettype wire

// >>> bcps_slow_div.sv
// Slow-mode programmable clock divider with 50% duty output
`timescale 1ns/1ps
`default_nettype none
module bcps_slow_div (
   input  wire logic  clk,
   input  wire logic  rst_n,
   bcps_clk_if.gen    dif
);
   import bcps_pkg::*;

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       out_r;
   logic       out_nxt;

   // ---------------------------------------------------------------
   // Divide: toggle every (setting+1) crystal ticks; setting 0 = half crystal
   // ---------------------------------------------------------------
   always_comb begin
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      if (dif.slow_tick) begin
         if (cnt_r >= dif.slow_div) begin
            cnt_nxt = 8'h00;
            out_nxt = ~out_r;
         end else begin
            cnt_nxt = cnt_r + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
         out_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
      end
   end

   assign dif.slow_clk = out_r;
endmodule
`default_nettype wire

// >>> bcps_assertions.sv
// Checker: port assertions of the bus-control pin select block
`timescale 1ns/1ps
`default_nettype none
module bcps_assertions
   import bcps_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       access_active,
   input wire logic       access_read,
   input wire logic       addr_bit0,
   input wire logic       byte_size_flag,
   input wire logic       gpio7_out,
   input wire logic       gpio7_oe_n,
   input wire logic       gpio6_out,
   input wire logic       gpio6_oe_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       port_e_bit7,
   input wire logic       port_e_bit7_oe_n,
   input wire logic       port_e_bit6,
   input wire logic       port_e_bit6_oe_n,
   input wire logic       bus_clock_out,
   input wire logic       low_byte_strobe_n,
   input wire logic       read_write,
   input wire logic       bus_side_oe_n
);
   // ---------------------------------------------------------------
   // Shadow of the assignment register, trusted after a first write
   // ---------------------------------------------------------------
   logic [7:0] asg_r;
   logic [7:0] asg_nxt;
   logic       known_r;
   logic       known_nxt;
   always_comb begin
      asg_nxt = asg_r;
      known_nxt = known_r;
      if (reg_wr && reg_addr == REG_ASSIGN) begin
         asg_nxt = reg_wdata;
         known_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         asg_r <= 8'h00;
         known_r <= 1'b0;
      end else begin
         asg_r <= asg_nxt;
         known_r <= known_nxt;
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_STROBE_PHASE: assert property (!bus_side_oe_n |-> bus_clock_out)
      else $error("strobe low outside bus clock high phase");
   AST_STROBE_READ: assert property (!bus_side_oe_n |-> $past(access_read))
      else $error("strobe low outside a read");
   AST_CLK_HIGH: assert property ($rose(bus_clock_out) |=> bus_clock_out ##1 !bus_clock_out)
      else $error("bus clock high phase not two cycles");
   AST_CLK_LOW: assert property ($fell(bus_clock_out) |=> !bus_clock_out ##1 bus_clock_out)
      else $error("bus clock low phase not two cycles");
   AST_LOW_BYTE_STROBE_N_XNOR: assert property (!low_byte_strobe_n |-> $past(addr_bit0 ^ byte_size_flag))
      else $error("low byte strobe low against address and size");
   AST_LOW_BYTE_STROBE_N_OFF: assert property ($past(known_r) && !$past(asg_r[ASSIGN_LOW_STRB])
      |-> low_byte_strobe_n) else $error("low byte strobe active while disabled");
   AST_RW_DIR: assert property (!read_write |-> $past(access_active && !access_read))
      else $error("write direction without a write access");
   AST_RW_OFF: assert property ($past(known_r) && !$past(asg_r[ASSIGN_RDWR])
      |-> read_write) else $error("direction output active while disabled");
   AST_PIN6_GPIO: assert property ($past(known_r) && !($past(asg_r[ASSIGN_CLK_TEST])
      && !$past(asg_r[ASSIGN_QUEUE_TRK])) |-> port_e_bit6 == $past(gpio6_out)
      && port_e_bit6_oe_n == $past(gpio6_oe_n)) else $error("bit 6 not general I/O");
   AST_PIN7_GPIO: assert property ($past(known_r) && $past(asg_r[ASSIGN_STROBE_DIS])
      && !$past(asg_r[ASSIGN_REF_OUT]) |-> port_e_bit7 == $past(gpio7_out)
      && port_e_bit7_oe_n == $past(gpio7_oe_n)) else $error("bit 7 not general I/O");
endmodule
bind bcps_top bcps_assertions i_chk (.clk(clk), .rst_n(rst_n), .access_active(access_active),
   .access_read(access_read), .addr_bit0(addr_bit0), .byte_size_flag(byte_size_flag),
   .gpio7_out(gpio7_out), .gpio7_oe_n(gpio7_oe_n), .gpio6_out(gpio6_out),
   .gpio6_oe_n(gpio6_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .port_e_bit7(port_e_bit7), .port_e_bit7_oe_n(port_e_bit7_oe_n), .port_e_bit6(port_e_bit6),
   .port_e_bit6_oe_n(port_e_bit6_oe_n), .bus_clock_out(bus_clock_out),
   .low_byte_strobe_n(low_byte_strobe_n), .read_write(read_write),
   .bus_side_oe_n(bus_side_oe_n));
`default_nettype wire

// >>> bcps_ext_mem.sv
// Partner: external memory that drives the data bus when enabled
`timescale 1ns/1ps
`default_nettype none
module bcps_ext_mem (
   input  wire logic  clk,
   input  wire logic  bus_side_oe_n,
   output logic [7:0] data_bus,
   output logic       driving
);
   logic [7:0] last_r = 8'h00;
   // Drives only while the strobe opens its output stage
   assign driving = !bus_side_oe_n;
   // Released bus shows the inverse of the last value
   assign data_bus = driving ? 8'ha5 : ~last_r;
   always_ff @(posedge clk) begin
      last_r <= data_bus;
   end
endmodule
`default_nettype wire

// >>> bcps_top_tb.sv
// Testbench: register-driven tests of the bus-control pin select block
`timescale 1ns/1ps
`default_nettype none
module bcps_top_tb;
   import bcps_pkg::*;
   logic clk = 0, rst_n = 0, msa = 0, msb = 0, act = 0, rdn = 0, a0 = 0, sz = 0, tci = 0;
   logic g7 = 0, g7oe = 1, g6 = 0, g6oe = 1, wr_s = 0, rd_s = 0;
   logic [3:0] ra = 4'h0;
   logic [7:0] wd = 8'h00, rdat, dbus;
   logic p7, p7oe, p6, p6oe, eck, lsb, rw, boe, drv;
   int mismatches = 0, compares = 0, cycles = 0, hi, rs;
   logic [7:0] v;
   always #5 clk = ~clk;
   bcps_top i_dut (.clk(clk), .rst_n(rst_n), .mode_select_a(msa), .mode_select_b(msb),
      .access_active(act), .access_read(rdn), .addr_bit0(a0), .byte_size_flag(sz),
      .test_clock_in(tci), .gpio7_out(g7), .gpio7_oe_n(g7oe), .gpio6_out(g6),
      .gpio6_oe_n(g6oe), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
      .reg_rdata(rdat), .port_e_bit7(p7), .port_e_bit7_oe_n(p7oe), .port_e_bit6(p6),
      .port_e_bit6_oe_n(p6oe), .bus_clock_out(eck), .low_byte_strobe_n(lsb),
      .read_write(rw), .bus_side_oe_n(boe));
   bcps_ext_mem i_mem (.clk(clk), .bus_side_oe_n(boe), .data_bus(dbus), .driving(drv));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      ra <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdat;
   endtask
   task automatic do_reset(input logic [1:0] m);
      rst_n <= 1'b0;
      {msb, msa} <= m;
      cyc(16);
      rst_n <= 1'b1;
      cyc(3);
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return eck;
         1: return p7;
         default: return drv && (dbus == 8'ha5);
      endcase
   endfunction
   task automatic sample(input int n, input int w);
      logic p, s;
      hi = 0;
      rs = 0;
      p = pick(w);
      repeat (n) begin
         cyc(1);
         s = pick(w);
         hi += int'(s);
         rs += int'(s && !p);
         p = s;
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   logic [7:0] asg_t [5] = '{8'h00, 8'h10, 8'h82, 8'h80, 8'h02};
   logic [1:0] sel_t [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
   initial begin
      do_reset(2'h0);
      rd(REG_ASSIGN, v); chk("assign single", v, 8'h80);
      rd(REG_STATUS, v); chk("status single", v & 8'h08, 8'h00);
      rd(REG_SLOW_DIV, v); chk("slow div", v, 8'h00);
      rd(4'hf, v); chk("unmapped", v, 8'h00);
      g7 <= 1'b1; g7oe <= 1'b0; cyc(3); chk("bit7 gpio", {7'h0, p7}, 8'h01);
      chk("bit7 oe", {7'h0, p7oe}, 8'h00);
      wr(REG_ASSIGN, 8'h88);
      for (int i = 0; i < 4; i++) begin
         a0 <= i[0]; sz <= i[1]; cyc(3);
         chk("low strobe", {7'h0, lsb}, {7'h0, i[0] ~^ i[1]});
      end
      wr(REG_ASSIGN, 8'h80); cyc(2); chk("low strobe off", {7'h0, lsb}, 8'h01);
      wr(REG_ASSIGN, 8'h40);
      tci <= 1'b1; cyc(6); chk("test clk hi", {7'h0, p6}, 8'h01);
      chk("test clk oe", {7'h0, p6oe}, 8'h00);
      tci <= 1'b0; cyc(6); chk("test clk lo", {7'h0, p6}, 8'h00);
      wr(REG_ASSIGN, 8'h60); g6 <= 1'b1; g6oe <= 1'b0; cyc(3);
      chk("bit6 gpio", {7'h0, p6}, 8'h01);
      chk("bit6 oe", {7'h0, p6oe}, 8'h00);
      do_reset(2'h3);
      rd(REG_ASSIGN, v); chk("assign expanded", v, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(REG_ASSIGN, asg_t[i]); rd(REG_STATUS, v);
         chk("pin7 select", v & 8'h0e, {4'h1, sel_t[i], 1'b0});
      end
      sample(40, 0); chk("bus_clock_out rises", rs[7:0], 8'h0a); chk("bus_clock_out high", hi[7:0], 8'h14);
      wr(REG_ASSIGN, 8'h10);
      repeat (8) begin
         cyc(1); chk("inverted clock", {7'h0, p7}, {7'h0, ~eck});
      end
      wr(REG_SLOW_DIV, 8'h02); wr(REG_ASSIGN, 8'h82);
      sample(24, 1); chk("slow rises", rs[7:0], 8'h04); chk("slow high", hi[7:0], 8'h0c);
      wr(REG_ASSIGN, 8'h04);
      act <= 1'b1; rdn <= 1'b0; cyc(3); chk("rw write", {7'h0, rw}, 8'h00);
      rdn <= 1'b1; cyc(3); chk("rw read", {7'h0, rw}, 8'h01);
      act <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         wr(REG_STRETCH, s[7:0]); wr(REG_ASSIGN, 8'h00);
         for (int k = 0; k < 20 && eck !== 1'b1; k++) cyc(1);
         for (int k = 0; k < 20 && eck !== 1'b0; k++) cyc(1);
         act <= 1'b1;
         fork
            begin cyc(4 * (s + 1)); act <= 1'b0; end
            begin
               sample(6 * s, 2);
               chk("strobe early", hi[7:0], 8'h00);
               sample(16 - 6 * s, 2);
            end
         join
         chk("strobe cycles", hi[7:0], s == 0 ? 8'h02 : 8'h01);
      end
      finish_test();
   end
endmodule
`default_nettype wire
